// [verilog/bsc_consts.vh]
`ifndef BSC_CONSTS_VH
`define BSC_CONSTS_VH

// =====================================================================
// command codes, taken with the data/command select low
// =====================================================================
`define BSC_CMD_CLEAR_BUSY_RD   8'h4e
`define BSC_CMD_DEEP_SLEEP      8'h4f
`define BSC_CMD_BRIGHTNESS_WR   8'h51
`define BSC_CMD_BRIGHTNESS_RD   8'h52
`define BSC_CMD_DISP_CTRL_WR    8'h53
`define BSC_CMD_DISP_CTRL_RD    8'h54

// =====================================================================
// parameter field positions
// =====================================================================
`define BSC_BUSY_BIT            0
`define BSC_DEEP_SLEEP_BIT      0
`define BSC_BACKLIGHT_BIT       2
`define BSC_BRIGHT_CTRL_BIT     5

// =====================================================================
// reset values
// =====================================================================
`define BSC_RST_BYTE            8'h00
`define BSC_RST_BIT             1'b0
`define BSC_DUMMY_BYTE          8'h00
`define BSC_PIN_SYNC_RST        12'he00

// =====================================================================
// timing
// =====================================================================
`define BSC_CLK_PERIOD_NS       8
`define BSC_HW_EXIT_TIME_NS     1000000

`endif

// [verilog/bsc_pin_sync.v]
`timescale 1ns/1ps

module bsc_pin_sync #(
  parameter             WIDTH     = 12,
  parameter [WIDTH-1:0] RST_VALUE = {WIDTH{1'b0}}
) (
  input  wire             SYS_CLK,
  input  wire             RST_N,
  input  wire [WIDTH-1:0] PIN_IN,
  output wire [WIDTH-1:0] PIN_SYNC
);

  // =====================================================================
  // two-flop synchroniser, one chain per bit
  // =====================================================================
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1;
      reg stage2;
      // first stage feeds only the second, to let metastability settle
      always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          stage1 <= RST_VALUE[i];
          stage2 <= RST_VALUE[i];
        end else begin
          stage1 <= PIN_IN[i];
          stage2 <= stage1;
        end
      end
      assign PIN_SYNC[i] = stage2;
    end
  endgenerate

endmodule

// [verilog/bsc_brightness_standby.v]
`timescale 1ns/1ps
`include "bsc_consts.vh"

module bsc_brightness_standby #(
  parameter HW_EXIT_CYCLES = (`BSC_HW_EXIT_TIME_NS + `BSC_CLK_PERIOD_NS - 1)
                             / `BSC_CLK_PERIOD_NS
) (
  input  wire       SYS_CLK,
  input  wire       RST_N,
  input  wire       HW_RESET_N,
  input  wire       SW_RESET,
  input  wire       DATA_COMMAND_SELECT,
  input  wire       WRITE_STROBE_N,
  input  wire       READ_STROBE_N,
  input  wire [7:0] DB_IN,
  output reg  [7:0] DB_OUT,
  output reg        DB_OE,
  input  wire       SLEEP_IN,
  input  wire       CLEAR_IN_PROGRESS,
  output reg        DEEP_STANDBY,
  output reg        BACKLIGHT_ON,
  output reg  [7:0] BACKLIGHT_LEVEL,
  output reg  [7:0] BRIGHTNESS_REPORT
);

  // =====================================================================
  // parser states
  // =====================================================================
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_WRITE = 2'b01;
  localparam [1:0] ST_READ  = 2'b10;

  localparam [1:0] IDX_LAST = 2'b11;
  localparam [16:0] EXIT_COUNT = HW_EXIT_CYCLES[16:0];

  // =====================================================================
  // pin synchronisers
  // =====================================================================
  wire [11:0] pin_sync;

  // every bus pin and the reset pin cross in through two flops
  bsc_pin_sync #(
    .WIDTH     (12),
    .RST_VALUE (`BSC_PIN_SYNC_RST)
  ) u_pin_sync (
    .SYS_CLK  (SYS_CLK),
    .RST_N    (RST_N),
    .PIN_IN   ({HW_RESET_N, READ_STROBE_N, WRITE_STROBE_N,
                DATA_COMMAND_SELECT, DB_IN}),
    .PIN_SYNC (pin_sync)
  );

  wire       hw_n_s   = pin_sync[11];
  wire       rd_n_s   = pin_sync[10];
  wire       wr_n_s   = pin_sync[9];
  wire       dcx_s    = pin_sync[8];
  wire [7:0] db_s     = pin_sync[7:0];

  // =====================================================================
  // strobe edge detection
  // =====================================================================
  reg wr_n_prev;
  reg rd_n_prev;

  // previous strobe levels, taken from the settled second stage only
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_n_prev <= 1'b1;
      rd_n_prev <= 1'b1;
    end else begin
      wr_n_prev <= wr_n_s;
      rd_n_prev <= rd_n_s;
    end
  end

  wire wr_rise = wr_n_s & ~wr_n_prev;
  wire rd_rise = rd_n_s & ~rd_n_prev;
  wire rd_fall = ~rd_n_s & rd_n_prev;

  // data and select share the strobe's delay, so they are aligned here
  wire cmd_taken   = wr_rise & ~dcx_s;
  wire param_taken = wr_rise & dcx_s;

  // =====================================================================
  // reset sources
  // =====================================================================
  wire hw_low    = ~hw_n_s;
  wire clear_all = hw_low | SW_RESET;

  // =====================================================================
  // hardware reset hold timer
  // =====================================================================
  reg  [16:0] hold_count;
  wire        hold_done = (hold_count == EXIT_COUNT);

  // counts how long the reset pin has stayed low; saturates at the target
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_count <= 17'h00000;
    end else if (!hw_low) begin
      hold_count <= 17'h00000;
    end else if (!hold_done) begin
      hold_count <= hold_count + 17'h00001;
    end
  end

  // =====================================================================
  // command parser
  // =====================================================================
  reg [1:0] state;
  reg [7:0] cmd;
  reg [1:0] par_idx;
  reg [1:0] next_state;

  // classify a newly taken command byte; unknown codes return the parser to idle
  always @* begin
    case (db_s)
      `BSC_CMD_DEEP_SLEEP,
      `BSC_CMD_BRIGHTNESS_WR,
      `BSC_CMD_DISP_CTRL_WR: begin
        next_state = ST_WRITE;
      end
      `BSC_CMD_CLEAR_BUSY_RD,
      `BSC_CMD_BRIGHTNESS_RD,
      `BSC_CMD_DISP_CTRL_RD: begin
        next_state = ST_READ;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // a command restarts the parameter count; deep standby freezes the bus
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state   <= ST_IDLE;
      cmd     <= `BSC_RST_BYTE;
      par_idx <= 2'b00;
    end else if (clear_all || DEEP_STANDBY) begin
      state   <= ST_IDLE;
      cmd     <= `BSC_RST_BYTE;
      par_idx <= 2'b00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_taken) begin
            state   <= next_state;
            cmd     <= db_s;
            par_idx <= 2'b00;
          end
        end
        ST_WRITE: begin
          if (cmd_taken) begin
            state   <= next_state;
            cmd     <= db_s;
            par_idx <= 2'b00;
          end else if (param_taken && par_idx != IDX_LAST) begin
            par_idx <= par_idx + 2'b01;
          end
        end
        ST_READ: begin
          if (cmd_taken) begin
            state   <= next_state;
            cmd     <= db_s;
            par_idx <= 2'b00;
          end else if (rd_rise && par_idx != IDX_LAST) begin
            par_idx <= par_idx + 2'b01;
          end
        end
        default: begin
          state   <= ST_IDLE;
          par_idx <= 2'b00;
        end
      endcase
    end
  end

  // only the first parameter of a write is acted on; extras are dropped
  wire first_param = (state == ST_WRITE) && param_taken && (par_idx == 2'b00);

  // =====================================================================
  // stored control values
  // =====================================================================
  reg [7:0] brightness;
  reg       bright_ctrl_en;
  reg       backlight;

  // sleep clears the brightness and wins over a write in the same cycle
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brightness <= `BSC_RST_BYTE;
    end else if (clear_all) begin
      brightness <= `BSC_RST_BYTE;
    end else if (SLEEP_IN) begin
      brightness <= `BSC_RST_BYTE;
    end else if (first_param && cmd == `BSC_CMD_BRIGHTNESS_WR) begin
      brightness <= db_s;
    end
  end

  // display control byte: backlight and brightness-control enable
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bright_ctrl_en <= `BSC_RST_BIT;
      backlight      <= `BSC_RST_BIT;
    end else if (clear_all) begin
      bright_ctrl_en <= `BSC_RST_BIT;
      backlight      <= `BSC_RST_BIT;
    end else if (first_param && cmd == `BSC_CMD_DISP_CTRL_WR) begin
      bright_ctrl_en <= db_s[`BSC_BRIGHT_CTRL_BIT];
      backlight      <= db_s[`BSC_BACKLIGHT_BIT];
    end
  end

  // =====================================================================
  // deep standby
  // =====================================================================
  wire standby_req = first_param && (cmd == `BSC_CMD_DEEP_SLEEP)
                     && db_s[`BSC_DEEP_SLEEP_BIT];

  // entry needs sleep-in; only a long enough hardware reset leaves it,
  // a short glitch on the pin does not wake the panel
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DEEP_STANDBY <= `BSC_RST_BIT;
    end else if (DEEP_STANDBY) begin
      if (hw_low && hold_done) begin
        DEEP_STANDBY <= `BSC_RST_BIT;
      end
    end else if (standby_req && SLEEP_IN && !clear_all) begin
      DEEP_STANDBY <= 1'b1;
    end
  end

  // =====================================================================
  // read-back values
  // =====================================================================
  wire [7:0] reported_bright = bright_ctrl_en ? brightness
                                              : `BSC_RST_BYTE;
  reg  [7:0] read_value;

  // byte presented for the current command and parameter index
  always @* begin
    read_value = `BSC_DUMMY_BYTE;
    case (cmd)
      `BSC_CMD_CLEAR_BUSY_RD: begin
        if (par_idx == 2'b00) begin
          read_value[`BSC_BUSY_BIT] = CLEAR_IN_PROGRESS;
        end
      end
      `BSC_CMD_BRIGHTNESS_RD: begin
        if (par_idx == 2'b01) begin
          read_value = reported_bright;
        end
      end
      `BSC_CMD_DISP_CTRL_RD: begin
        if (par_idx == 2'b01) begin
          read_value[`BSC_BACKLIGHT_BIT]   = backlight;
          read_value[`BSC_BRIGHT_CTRL_BIT] = bright_ctrl_en;
        end
      end
      default: begin
        read_value = `BSC_DUMMY_BYTE;
      end
    endcase
  end

  // =====================================================================
  // data bus drive
  // =====================================================================
  // byte is frozen at the strobe's falling edge so it cannot change
  // while the host samples; index 0 of a two-byte read is the dummy
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DB_OUT <= `BSC_RST_BYTE;
      DB_OE  <= 1'b0;
    end else if (clear_all || DEEP_STANDBY) begin
      DB_OUT <= `BSC_RST_BYTE;
      DB_OE  <= 1'b0;
    end else begin
      if (rd_fall && state == ST_READ) begin
        DB_OUT <= read_value;
      end
      DB_OE <= ~rd_n_s && (state == ST_READ) && dcx_s;
    end
  end

  // =====================================================================
  // panel outputs
  // =====================================================================
  // identity mapping keeps the level monotonic in the stored value;
  // with the backlight off BACKLIGHT_ON and BACKLIGHT_LEVEL are forced low; BRIGHTNESS_REPORT follows the stored value only with brightness control on
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BACKLIGHT_ON      <= `BSC_RST_BIT;
      BACKLIGHT_LEVEL   <= `BSC_RST_BYTE;
      BRIGHTNESS_REPORT <= `BSC_RST_BYTE;
    end else begin
      BACKLIGHT_ON      <= backlight;
      BACKLIGHT_LEVEL   <= backlight ? brightness : `BSC_RST_BYTE;
      BRIGHTNESS_REPORT <= reported_bright;
    end
  end

endmodule

// [verification/bsc_chk_asserts.sv]
`timescale 1ns/1ps
// ==================================================
// port checker for the brightness and standby block
// ==================================================
module bsc_chk #(
  parameter HW_EXIT_CYCLES = 20
) (
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic       HW_RESET_N,
  input wire logic       SW_RESET,
  input wire logic       DATA_COMMAND_SELECT,
  input wire logic       WRITE_STROBE_N,
  input wire logic       READ_STROBE_N,
  input wire logic [7:0] DB_IN,
  input wire logic [7:0] DB_OUT,
  input wire logic       DB_OE,
  input wire logic       SLEEP_IN,
  input wire logic       CLEAR_IN_PROGRESS,
  input wire logic       DEEP_STANDBY,
  input wire logic       BACKLIGHT_ON,
  input wire logic [7:0] BACKLIGHT_LEVEL,
  input wire logic [7:0] BRIGHTNESS_REPORT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // backlight off must leave the drive level at zero
  property p_bl_off; !BACKLIGHT_ON && !$past(BACKLIGHT_ON) |-> BACKLIGHT_LEVEL == 8'h00; endproperty
  a_bl_off: assert property (p_bl_off) else $error("level driven with backlight off");
  // standby entry only from sleep-in
  property p_deep_sleep; $rose(DEEP_STANDBY) |-> $past(SLEEP_IN); endproperty
  a_deep_sleep: assert property (p_deep_sleep) else $error("standby entered awake");
  // sleep wipes the brightness
  property p_sleep_clr; SLEEP_IN [*3] |=> BRIGHTNESS_REPORT == 8'h00; endproperty
  a_sleep_clr: assert property (p_sleep_clr) else $error("brightness kept in sleep");
  // software reset clears the brightness and the backlight
  property p_sw_clr;
    SW_RESET [*3] |=> BRIGHTNESS_REPORT == 8'h00 && !BACKLIGHT_ON && BACKLIGHT_LEVEL == 8'h00;
  endproperty
  a_sw_clr: assert property (p_sw_clr) else $error("values kept over soft reset");
  // bus drive starts only after a read strobe has fallen
  property p_oe_fall; $rose(DB_OE) |-> !READ_STROBE_N && !$past(READ_STROBE_N, 2); endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("bus driven without read strobe");
  // reads answer only in the parameter phase
  property p_oe_dc; $rose(DB_OE) |-> $past(DATA_COMMAND_SELECT, 2); endproperty
  a_oe_dc: assert property (p_oe_dc) else $error("bus driven in command phase");
  // bus released shortly after the read strobe rises
  property p_oe_drop; $rose(READ_STROBE_N) |-> ##[2:5] !DB_OE; endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("bus not released");
  // read data holds between read strobes
  property p_db_hold; (READ_STROBE_N && HW_RESET_N && !SW_RESET) [*4] |-> $stable(DB_OUT);
  endproperty
  a_db_hold: assert property (p_db_hold) else $error("read data moved while idle");
  // standby is left only under a hardware reset pulse
  property p_deep_exit; $fell(DEEP_STANDBY) |-> !$past(HW_RESET_N, 3); endproperty
  a_deep_exit: assert property (p_deep_exit) else $error("standby left without reset pin");
endmodule

bind bsc_brightness_standby bsc_chk #(.HW_EXIT_CYCLES(HW_EXIT_CYCLES)) u_chk (.*);

// [verification/bsc_host_model.sv]
`timescale 1ns/1ps
// ==================================================
// host processor on the parallel command bus
// ==================================================
module bsc_host_model (
  input  wire       SYS_CLK,
  input  wire [7:0] DB_OUT,
  input  wire       DB_OE,
  output reg        DATA_COMMAND_SELECT,
  output reg        WRITE_STROBE_N,
  output reg        READ_STROBE_N,
  output reg  [7:0] DB_IN,
  output reg        HW_RESET_N
);
  // pins idle at time zero
  initial begin
    DATA_COMMAND_SELECT = 1'b1;
    WRITE_STROBE_N = 1'b1;
    READ_STROBE_N = 1'b1;
    DB_IN = 8'h00;
    HW_RESET_N = 1'b1;
  end
  // one byte; select and data settle 2 clocks before the falling strobe
  task xfer(input logic dc, input logic rd, input logic [7:0] d, output logic [7:0] q);
    begin
      @(posedge SYS_CLK);
      DATA_COMMAND_SELECT <= dc;
      DB_IN <= rd ? ~DB_IN : d;
      repeat (2) @(posedge SYS_CLK);
      if (rd) READ_STROBE_N <= 1'b0;
      else WRITE_STROBE_N <= 1'b0;
      repeat (6) @(posedge SYS_CLK);
      q = DB_OE ? DB_OUT : 8'hxx; // undriven bus never passes
      READ_STROBE_N <= 1'b1;
      WRITE_STROBE_N <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      DB_IN <= ~DB_IN; // released lines toggle, no stale value
      repeat (2) @(posedge SYS_CLK);
    end
  endtask
  // hardware reset pulse of n clocks
  task hw_reset(input int n);
    begin
      @(posedge SYS_CLK);
      HW_RESET_N <= 1'b0;
      repeat (n) @(posedge SYS_CLK);
      HW_RESET_N <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
    end
  endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
// ==================================================
// testbench top
// ==================================================
module tb_top;
  localparam EXIT = 20;
  logic sys_clk = 1'b0, rst_n = 1'b0, sw_reset = 1'b0, sleep_in = 1'b0, clear_busy = 1'b0;
  wire dc, wr_n, rd_n, hw_n, db_oe, deep, bl_on;
  wire [7:0] db_in, db_out, bl_level, report;
  int n_errors = 0, check_count = 0;
  logic [7:0] q;
  always #4 sys_clk = ~sys_clk;
  bsc_host_model host (.SYS_CLK(sys_clk), .DB_OUT(db_out), .DB_OE(db_oe),
    .DATA_COMMAND_SELECT(dc), .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n), .DB_IN(db_in),
    .HW_RESET_N(hw_n));
  bsc_brightness_standby #(.HW_EXIT_CYCLES(EXIT)) dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .HW_RESET_N(hw_n), .SW_RESET(sw_reset), .DATA_COMMAND_SELECT(dc), .WRITE_STROBE_N(wr_n),
    .READ_STROBE_N(rd_n), .DB_IN(db_in), .DB_OUT(db_out), .DB_OE(db_oe), .SLEEP_IN(sleep_in),
    .CLEAR_IN_PROGRESS(clear_busy), .DEEP_STANDBY(deep), .BACKLIGHT_ON(bl_on),
    .BACKLIGHT_LEVEL(bl_level), .BRIGHTNESS_REPORT(report));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // command then one parameter
  task wr(input logic [7:0] c, input logic [7:0] p);
    host.xfer(1'b0, 1'b0, c, q);
    host.xfer(1'b1, 1'b0, p, q);
    // registered outputs move on the edge the task returns at; look one edge later
    @(posedge sys_clk);
  endtask
  // command then first read byte
  task rd(input logic [7:0] c, input logic [7:0] e);
    host.xfer(1'b0, 1'b0, c, q);
    nxt(e);
  endtask
  task nxt(input logic [7:0] e);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, e);
  endtask
  task conclude;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({deep, bl_on, 6'h00}, 8'h00);
    chk(report, 8'h00);
    rd(8'h52, 8'h00);
    nxt(8'h00);
    wr(8'h53, 8'h24);
    chk({7'h00, bl_on}, 8'h01);
    wr(8'h51, 8'ha5);
    rd(8'h52, 8'h00);
    nxt(8'ha5);
    chk(bl_level, 8'ha5);
    chk(report, 8'ha5);
    rd(8'h54, 8'h00);
    nxt(8'h24);
    wr(8'h53, 8'h20);
    chk({7'h00, bl_on}, 8'h00);
    chk(bl_level, 8'h00);
    wr(8'h53, 8'h04);
    rd(8'h52, 8'h00);
    nxt(8'h00);
    $display("brightness and backlight done");
    clear_busy <= 1'b1;
    rd(8'h4e, 8'h01);
    clear_busy <= 1'b0;
    rd(8'h4e, 8'h00);
    wr(8'h4f, 8'h01);
    chk({7'h00, deep}, 8'h00);
    wr(8'h53, 8'h24);
    sleep_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(report, 8'h00);
    wr(8'h51, 8'h33);
    chk(report, 8'h00);
    wr(8'h4f, 8'h00);
    chk({7'h00, deep}, 8'h00);
    wr(8'h4f, 8'h01);
    chk({7'h00, deep}, 8'h01);
    sleep_in <= 1'b0;
    wr(8'h51, 8'h44);
    chk(report, 8'h00);
    host.hw_reset(EXIT / 4);
    chk({7'h00, deep}, 8'h01);
    host.hw_reset(EXIT + 10);
    chk({7'h00, deep}, 8'h00);
    $display("status and standby done");
    wr(8'h53, 8'h24);
    wr(8'h51, 8'h5a);
    chk(report, 8'h5a);
    sw_reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sw_reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, bl_on}, 8'h00);
    chk(report, 8'h00);
    wr(8'h53, 8'h24);
    wr(8'h51, 8'h77);
    host.hw_reset(EXIT / 4);
    chk({7'h00, bl_on}, 8'h00);
    chk(report, 8'h00);
    $display("resets done");
    conclude();
  end
endmodule
